// ==== src/lcd_cmd_core.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

// Function
// - Both lines released high while bus idle.
// - Data command loads six-bit start pointer.
// - Accept one or many display bytes.
// - Reads return consecutive display bytes.
// - Single byte write stores one byte.
// - Mode command sets duty and bias.
// - System command gates oscillator then display.
// - Frame command selects 80 or 160 Hz.
// - Blink command selects off, 4, 2, 1 Hz.
// - Trim command sets select, regulator, level.
// - Select bit routes pad: supply or column.
// - Zero level code disables voltage follower.
// - Select set, regulator clear forces follower off.
// - Reset: regulator on, pad is column output.
// - Reject line glitches shorter than 50 ns.
// - 52 bytes; byte n drives column n.
// - Frame timing derived from 32 kHz clock.
// - Display and oscillator off means power save.
module lcd_cmd_core (
    input  wire logic           clk_in,
    input  wire logic           rst_in,
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    output logic                sda_out,
    output logic                sda_oe_n_out,
    input  wire logic [5:0]     scan_addr_in,
    output logic      [7:0]     scan_data_out,
    output lcd_pkg::lcd_cfg_t   cfg_out,
    output logic                pad_is_column_out,
    output logic                follower_on_out,
    output logic                power_save_out,
    output logic                frame_tick_out,
    output logic                blank_out
);
    import lcd_pkg::*;

    // ======================================================================
    // Declarations
    // ======================================================================
    logic [1:0]  line_s1;
    logic [1:0]  line_s2;
    logic [1:0]  line_f;
    logic [1:0]  line_prev;
    logic [2:0]  flt_cnt [2];
    lcd_state_t  state_reg;
    logic [3:0]  bit_cnt_reg;
    logic [1:0]  byte_idx_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  tx_reg;
    logic [7:0]  cmd_reg;
    logic        rw_reg;
    logic        nack_reg;
    logic [5:0]  ptr_reg;
    lcd_cfg_t    cfg_reg;
    logic [7:0]  rd_data;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;
    logic        byte_evt;
    logic        accept;
    logic        wr_evt;
    logic        arg_evt;
    logic        ram_we;
    logic        tx_load;
    logic [11:0] osc_cnt;
    logic        osc_tick;
    logic [8:0]  frame_cnt;
    logic [13:0] blink_cnt;
    logic [13:0] blink_half;
    logic        blink_phase;

    // Next pointer, wrapping after the last column.
    function automatic logic [5:0] ptr_inc(input logic [5:0] p);
        ptr_inc = (p >= `LCD_RAM_LAST) ? `LCD_PTR_RST : p + 6'h01;
    endfunction

    // ======================================================================
    // Pin synchronisers and glitch filter
    // ======================================================================
    // Index 0 is the clock line, index 1 the data line.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            line_s1 <= 2'h3;
            line_s2 <= 2'h3;
        end else begin
            line_s1 <= {sda_in, scl_in};
            line_s2 <= line_s1;
        end
    end

    // A level must differ for the full window before it is believed.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            line_f     <= 2'h3;
            line_prev  <= 2'h3;
            flt_cnt[0] <= 3'h0;
            flt_cnt[1] <= 3'h0;
        end else begin
            line_prev <= line_f;
            for (int i = 0; i < 2; i++) begin
                if (line_s2[i] == line_f[i]) begin
                    flt_cnt[i] <= 3'h0;
                end else if (flt_cnt[i] == 3'(`LCD_GLITCH_CYC - 1)) begin
                    line_f[i]  <= line_s2[i];
                    flt_cnt[i] <= 3'h0;
                end else begin
                    flt_cnt[i] <= flt_cnt[i] + 3'h1;
                end
            end
        end
    end

    // Edge and bus condition decode on the filtered lines.
    assign scl_rise  = line_f[0] & ~line_prev[0];
    assign scl_fall  = ~line_f[0] & line_prev[0];
    assign bus_start = line_f[0] & line_prev[0] & ~line_f[1] & line_prev[1];
    assign bus_stop  = line_f[0] & line_prev[0] & line_f[1] & ~line_prev[1];

    // ======================================================================
    // Byte engine
    // ======================================================================
    assign byte_evt = (state_reg == ST_RX) && scl_fall &&
                      (bit_cnt_reg == `LCD_BIT_FULL);
    assign accept   = (byte_idx_reg != 2'd0) ||
                      (shift_reg[7:1] == `LCD_DEV_ADDR);
    assign wr_evt   = byte_evt && (byte_idx_reg != 2'd0) && !rw_reg;
    assign arg_evt  = wr_evt && (byte_idx_reg == `LCD_BYTE_ARG);
    assign ram_we   = wr_evt && (byte_idx_reg == `LCD_BYTE_DATA) &&
                      (cmd_reg == `LCD_CMD_DATA);
    assign tx_load  = scl_fall && ((state_reg == ST_ACK && rw_reg) ||
                      (state_reg == ST_MACK && !nack_reg));

    // Bus state, shifting and the open-drain data enable.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg    <= ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= 2'd0;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            rw_reg       <= 1'b0;
            nack_reg     <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end else if (bus_stop) begin
            state_reg    <= ST_IDLE;
            sda_oe_n_out <= 1'b1;
        end else if (bus_start) begin
            state_reg    <= ST_RX;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= 2'd0;
            rw_reg       <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    sda_oe_n_out <= 1'b1;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], line_f[1]};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_evt) begin
                        if (byte_idx_reg == 2'd0) begin
                            rw_reg <= shift_reg[0];
                        end
                        if (byte_idx_reg != `LCD_BYTE_DATA) begin
                            byte_idx_reg <= byte_idx_reg + 2'd1;
                        end
                        state_reg    <= accept ? ST_ACK : ST_IDLE;
                        sda_oe_n_out <= !accept;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg) begin
                            state_reg    <= ST_TX;
                            tx_reg       <= rd_data;
                            sda_oe_n_out <= rd_data[7];
                        end else begin
                            state_reg    <= ST_RX;
                            sda_oe_n_out <= 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == `LCD_BIT_LAST) begin
                            state_reg    <= ST_MACK;
                            sda_oe_n_out <= 1'b1;
                        end else begin
                            tx_reg       <= {tx_reg[6:0], 1'b0};
                            sda_oe_n_out <= tx_reg[6];
                            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    // A high data line at the ninth clock ends the read.
                    if (scl_rise) begin
                        nack_reg <= line_f[1];
                    end else if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (nack_reg) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg    <= ST_TX;
                            tx_reg       <= rd_data;
                            sda_oe_n_out <= rd_data[7];
                        end
                    end
                end
            endcase
        end
    end

    // The pin only ever pulls low; the enable carries the data.
    always_ff @(posedge clk_in) begin
        sda_out <= 1'b0;
    end

    // ======================================================================
    // Command decode and configuration
    // ======================================================================
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cmd_reg <= 8'h00;
        end else if (wr_evt && byte_idx_reg == 2'd1) begin
            cmd_reg <= shift_reg;
        end
    end

    // Only the second byte of a known command touches the settings.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg_reg <= `LCD_CFG_RST;
        end else if (arg_evt) begin
            case (cmd_reg)
                `LCD_CMD_MODE: begin
                    cfg_reg.duty_8 <= shift_reg[`LCD_DUTY_BIT];
                    cfg_reg.bias_4 <= shift_reg[`LCD_BIAS_BIT];
                end
                `LCD_CMD_SYS: begin
                    cfg_reg.osc_on     <= shift_reg[`LCD_OSC_BIT];
                    cfg_reg.display_on <= shift_reg[`LCD_OSC_BIT] &
                                          shift_reg[`LCD_DISP_BIT];
                end
                `LCD_CMD_FRAME: begin
                    cfg_reg.frame_160 <= shift_reg[`LCD_FRAME_BIT];
                end
                `LCD_CMD_BLINK: begin
                    cfg_reg.blink_rate <= shift_reg[`LCD_BLINK_MSB:0];
                end
                `LCD_CMD_TRIM: begin
                    cfg_reg.shared_pin_select <= shift_reg[`LCD_SHARED_BIT];
                    cfg_reg.regulator_on <= shift_reg[`LCD_REGON_BIT];
                    cfg_reg.level_code <= shift_reg[`LCD_LEVEL_MSB:0];
                end
                default: begin
                    cfg_reg <= cfg_reg;
                end
            endcase
        end
    end

    // Start address from the data command, then one step per byte.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ptr_reg <= `LCD_PTR_RST;
        end else if (arg_evt && cmd_reg == `LCD_CMD_DATA) begin
            ptr_reg <= shift_reg[`LCD_PTR_MSB:0];
        end else if (ram_we || tx_load) begin
            ptr_reg <= ptr_inc(ptr_reg);
        end
    end

    // Derived panel controls, each registered.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pad_is_column_out <= 1'b1;
            follower_on_out   <= 1'b0;
            power_save_out    <= 1'b1;
        end else begin
            pad_is_column_out <= cfg_reg.shared_pin_select;
            follower_on_out   <= (cfg_reg.level_code != 4'h0) &&
                !(cfg_reg.shared_pin_select && !cfg_reg.regulator_on);
            power_save_out <= !cfg_reg.osc_on && !cfg_reg.display_on;
        end
    end

    assign cfg_out = cfg_reg;

    // ======================================================================
    // Display memory
    // ======================================================================
    // The scan port is free running so the panel never waits on the bus.
    lcd_dram u_dram (
        .clk_in        (clk_in),
        .wr_en_in      (ram_we),
        .wr_addr_in    (ptr_reg),
        .wr_data_in    (shift_reg),
        .rd_a_addr_in  (ptr_reg),
        .rd_a_data_out (rd_data),
        .rd_b_addr_in  (scan_addr_in),
        .rd_b_data_out (scan_data_out)
    );

    // ======================================================================
    // Oscillator, frame and blink timing
    // ======================================================================
    // The divider stops with the oscillator, which is what saves power.
    always_ff @(posedge clk_in) begin
        if (rst_in || !cfg_reg.osc_on) begin
            osc_cnt  <= 12'h000;
            osc_tick <= 1'b0;
        end else if (osc_cnt == 12'(`LCD_OSC_DIV_CYC - 1)) begin
            osc_cnt  <= 12'h000;
            osc_tick <= 1'b1;
        end else begin
            osc_cnt  <= osc_cnt + 12'h001;
            osc_tick <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || !cfg_reg.osc_on) begin
            frame_cnt      <= 9'h000;
            frame_tick_out <= 1'b0;
        end else begin
            frame_tick_out <= 1'b0;
            if (osc_tick) begin
                if (frame_cnt >= (cfg_reg.frame_160 ?
                        9'(`LCD_FRAME_FAST - 1) : 9'(`LCD_FRAME_SLOW - 1))) begin
                    frame_cnt      <= 9'h000;
                    frame_tick_out <= 1'b1;
                end else begin
                    frame_cnt <= frame_cnt + 9'h001;
                end
            end
        end
    end

    // Half period of the chosen blink rate in oscillator ticks.
    always_comb begin
        unique case (cfg_reg.blink_rate)
            2'b01:   blink_half = 14'(`LCD_BLINK_4HZ - 1);
            2'b10:   blink_half = 14'(`LCD_BLINK_2HZ - 1);
            2'b11:   blink_half = 14'(`LCD_BLINK_1HZ - 1);
            default: blink_half = 14'h0000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || cfg_reg.blink_rate == 2'b00) begin
            blink_cnt   <= 14'h0000;
            blink_phase <= 1'b0;
            blank_out   <= 1'b0;
        end else begin
            blank_out <= blink_phase;
            if (osc_tick) begin
                if (blink_cnt >= blink_half) begin
                    blink_cnt   <= 14'h0000;
                    blink_phase <= !blink_phase;
                end else begin
                    blink_cnt <= blink_cnt + 14'h0001;
                end
            end
        end
    end

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_arg_of(logic [7:0] code);
        arg_evt && cmd_reg == code;
    endsequence

    a_idle_release: assert property (
        state_reg == ST_IDLE && $past(state_reg) == ST_IDLE |-> sda_oe_n_out)
        else $error("data line held while bus idle");
    a_ptr_load: assert property (
        s_arg_of(`LCD_CMD_DATA) |=> ptr_reg == $past(shift_reg[5:0]))
        else $error("start pointer not loaded");
    a_ram_advance: assert property (
        (ram_we || tx_load) |=> ptr_reg == ptr_inc($past(ptr_reg)))
        else $error("pointer did not advance");
    a_glitch_hold: assert property (
        $changed(line_f[0]) |-> $past(line_s2[0], 1) == line_f[0] &&
        $past(line_s2[0], 5) == line_f[0])
        else $error("clock glitch passed the filter");
    a_sys_gate: assert property (
        s_arg_of(`LCD_CMD_SYS) ##1 !cfg_reg.osc_on |-> !cfg_reg.display_on)
        else $error("display on without oscillator");
    a_follower_off: assert property (
        cfg_reg.shared_pin_select && !cfg_reg.regulator_on |=>
        !follower_on_out)
        else $error("follower not forced off");
    a_level_zero: assert property (
        cfg_reg.level_code == 4'h0 |=> !follower_on_out)
        else $error("follower on at zero level");
    a_power_save: assert property (
        !cfg_reg.osc_on && !cfg_reg.display_on ##1 $stable(cfg_reg)
        |-> power_save_out)
        else $error("power save not entered");
    a_unknown_cmd: assert property (
        arg_evt && !(cmd_reg inside {`LCD_CMD_DATA, `LCD_CMD_MODE,
        `LCD_CMD_SYS, `LCD_CMD_FRAME, `LCD_CMD_BLINK, `LCD_CMD_TRIM})
        |=> $stable(cfg_reg) && $stable(ptr_reg))
        else $error("unknown command changed state");
    a_frame_stop: assert property (
        !cfg_reg.osc_on ##1 !cfg_reg.osc_on |-> !frame_tick_out)
        else $error("frame tick with oscillator off");

endmodule

`default_nettype wire

// ==== src/lcd_cfg.svh ====
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// ==========================================================================
// Serial bus identity and command codes
// ==========================================================================
// Seven-bit bus address; the value is arbitrary.
`define LCD_DEV_ADDR      7'h3E
`define LCD_CMD_DATA      8'h80
`define LCD_CMD_MODE      8'h82
`define LCD_CMD_SYS       8'h84
`define LCD_CMD_FRAME     8'h86
`define LCD_CMD_BLINK     8'h88
`define LCD_CMD_TRIM      8'h8A

// ==========================================================================
// Display memory and reset values
// ==========================================================================
`define LCD_RAM_DEPTH     52
`define LCD_RAM_LAST      6'h33
`define LCD_PTR_RST       6'h00
`define LCD_CFG_RST       13'h0030
`define LCD_RD_BLANK      8'h00

// ==========================================================================
// Byte fields
// ==========================================================================
`define LCD_PTR_MSB       5
`define LCD_DUTY_BIT      1
`define LCD_BIAS_BIT      0
`define LCD_OSC_BIT       1
`define LCD_DISP_BIT      0
`define LCD_FRAME_BIT     0
`define LCD_SHARED_BIT    5
`define LCD_REGON_BIT     4
`define LCD_LEVEL_MSB     3
`define LCD_BLINK_MSB     1
`define LCD_BYTE_ARG      2'd2
`define LCD_BYTE_DATA     2'd3
`define LCD_BIT_LAST      4'd7
`define LCD_BIT_FULL      4'd8

// ==========================================================================
// Timing
// ==========================================================================
`define LCD_CLK_MHZ       100
`define LCD_GLITCH_NS     50
`define LCD_GLITCH_CYC    ((`LCD_GLITCH_NS * `LCD_CLK_MHZ + 999) / 1000)
`define LCD_OSC_KHZ       32
`define LCD_OSC_DIV_CYC   (`LCD_CLK_MHZ * 1000 / `LCD_OSC_KHZ)
`define LCD_FRAME_SLOW_HZ 80
`define LCD_FRAME_FAST_HZ 160
`define LCD_FRAME_SLOW    (`LCD_OSC_KHZ * 1000 / `LCD_FRAME_SLOW_HZ)
`define LCD_FRAME_FAST    (`LCD_OSC_KHZ * 1000 / `LCD_FRAME_FAST_HZ)
`define LCD_BLINK_4HZ     (`LCD_OSC_KHZ * 1000 / 8)
`define LCD_BLINK_2HZ     (`LCD_OSC_KHZ * 1000 / 4)
`define LCD_BLINK_1HZ     (`LCD_OSC_KHZ * 1000 / 2)

`endif

// ==== src/lcd_pkg.sv ====
package lcd_pkg;

    // ======================================================================
    // Types
    // ======================================================================
    // Bus engine states, Gray coded along receive, ack, send, master ack.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b011,
        ST_TX   = 3'b010,
        ST_MACK = 3'b110
    } lcd_state_t;

    // Panel configuration as written by the command bytes.
    typedef struct packed {
        logic       duty_8;
        logic       bias_4;
        logic       osc_on;
        logic       display_on;
        logic       frame_160;
        logic [1:0] blink_rate;
        logic       shared_pin_select;
        logic       regulator_on;
        logic [3:0] level_code;
    } lcd_cfg_t;

endpackage

// ==== src/lcd_dram.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

module lcd_dram (
    input  wire logic       clk_in,
    input  wire logic       wr_en_in,
    input  wire logic [5:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic [5:0] rd_a_addr_in,
    output logic      [7:0] rd_a_data_out,
    input  wire logic [5:0] rd_b_addr_in,
    output logic      [7:0] rd_b_data_out
);

    // ======================================================================
    // Storage
    // ======================================================================
    // Byte n holds row lines 0..7 of panel column n.
    logic [7:0] mem [`LCD_RAM_DEPTH];

    // Writes past the last column are dropped so the array never aliases.
    always_ff @(posedge clk_in) begin
        if (wr_en_in && wr_addr_in <= `LCD_RAM_LAST) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // Both read ports are registered; out of range reads return blank.
    always_ff @(posedge clk_in) begin
        if (rd_a_addr_in <= `LCD_RAM_LAST) begin
            rd_a_data_out <= mem[rd_a_addr_in];
        end else begin
            rd_a_data_out <= `LCD_RD_BLANK;
        end
        if (rd_b_addr_in <= `LCD_RAM_LAST) begin
            rd_b_data_out <= mem[rd_b_addr_in];
        end else begin
            rd_b_data_out <= `LCD_RD_BLANK;
        end
    end

endmodule

`default_nettype wire

// ==== dv/lcd_i2c_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// ================================================================
// Bus master model: it drives SCL both ways; the bench ANDs its SDA with the slave.
module lcd_i2c_master (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    // Both lines are released from time zero, so an idle bus rests high.
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // A quarter bit of 66 cycles keeps SCL under 400 kHz, low over 1.3 us.
    task automatic step(input logic c, input logic d);
        repeat (66) @(negedge clk_in);
        scl_out = c;
        sda_out = d;
    endtask
    // Start when s is set, stop otherwise; SDA is set up with SCL low, then toggled with SCL high.
    task automatic cond(input logic s);
        step(1'b0, s);
        step(1'b1, s);
        step(1'b1, !s);
        if (s) step(1'b0, 1'b0);
    endtask
    // Eight bits MSB first plus the acknowledge slot; each slot is
    // replaced by what the line showed in the middle of SCL high.
    task automatic xfer(input logic [8:0] d, output logic [8:0] v);
        v = d;
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, v[i]);
            repeat (2) step(1'b1, v[i]);
            v[i] = sda_in;
            step(1'b0, sda_out);
        end
    endtask
endmodule
`default_nettype wire

// ==== dv/lcd_cmd_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"
// ================================================================
// Command bench: bus traffic via the master model, port checks.
module lcd_cmd_core_tb;
    import lcd_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, scl, m_sda, s_sda, oe_n;
    logic        pad, fol, ps, ft, blk;
    logic [5:0]  scan_a = 6'h00;
    logic [7:0]  scan_d;
    logic [12:0] e;
    lcd_cfg_t    cfg;
    int          failures = 0, checks_done = 0;
    // The line is low whenever either party pulls it.
    wire logic   sda_line = m_sda & (oe_n | s_sda);
    // Command and argument pairs, and the configuration each leaves.
    // The last pair is an undefined command that must leave all as it was.
    logic [15:0] ca [10] = '{16'h8203, 16'h8401, 16'h8403, 16'h86FF,
        16'h88FD, 16'h8802, 16'h8803, 16'h8A2F, 16'h8AC5, 16'h903F};
    logic [12:0] ex [10] = '{13'h1830, 13'h1830, 13'h1E30, 13'h1F30,
        13'h1F70, 13'h1FB0, 13'h1FF0, 13'h1FEF, 13'h1FC5, 13'h1FC5};
    logic [7:0]  ram [3] = '{8'hC3, 8'hA5, 8'h5A};
    lcd_i2c_master m (.clk_in(clk), .sda_in(sda_line), .scl_out(scl),
        .sda_out(m_sda));
    lcd_cmd_core uut (.clk_in(clk), .rst_in(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(s_sda), .sda_oe_n_out(oe_n),
        .scan_addr_in(scan_a), .scan_data_out(scan_d), .cfg_out(cfg),
        .pad_is_column_out(pad), .follower_on_out(fol),
        .power_save_out(ps), .frame_tick_out(ft), .blank_out(blk));
    // Free-running 100 MHz clock.
    initial forever #5 clk = ~clk;
    // One comparison; four-state equality so an unknown never matches.
    task automatic chk(input string n, input logic [12:0] x,
        input logic [12:0] g);
        checks_done++;
        if (g !== x) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    // Writes send b; reads expect b and refuse the last byte.
    task automatic bus(input logic rd, input logic [7:0] b[$]);
        logic [8:0] v;
        m.cond(1'b1);
        m.xfer({`LCD_DEV_ADDR, rd, 1'b1}, v);
        chk("ack", 13'h0, v[0]);
        foreach (b[i]) begin
            m.xfer(rd ? {8'hFF, i == b.size() - 1} : {b[i], 1'b1}, v);
            chk("byte", rd ? b[i] : 8'h00, rd ? v[8:1] : {7'h0, v[0]});
        end
        m.cond(1'b0);
    endtask
    // Counts, then the verdict; the run always ends here.
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog a little beyond the roughly 106k cycles the sequence needs.
    initial begin
        repeat (115000) @(posedge clk);
        failures++;
        wrap_up();
    end
    // Reset, the command table, then display memory traffic.
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (12) @(negedge clk);
        chk("cfg", 13'h0030, cfg);
        chk("pad", 13'h1, pad);
        foreach (ca[k]) begin
            bus(1'b0, '{ca[k][15:8], ca[k][7:0]});
            repeat (3) @(negedge clk);
            e = ex[k];
            chk("cfg", e, cfg);
            chk("pad", e[5], pad);
            chk("follower", |e[3:0] && !(e[5] && !e[4]), fol);
            chk("power save", !e[10] && !e[9], ps);
            chk("sda idle", 13'h1, oe_n);
            chk("frame tick", 13'h0, ft);
            chk("blank", 13'h0, blk);
        end
        bus(1'b0, '{8'h80, 8'hF3, 8'hA5, 8'h5A});
        bus(1'b0, '{8'h80, 8'h32, 8'hC3});
        bus(1'b1, '{8'hA5, 8'h5A});
        foreach (ram[j]) begin
            scan_a = 6'((50 + j) % 52);
            repeat (2) @(negedge clk);
            chk("scan", ram[j], scan_d);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
